// file: rtl/ais_consts.svh
// Constants for the analog input scaling block and its controller.
// Assumes it is included by bare name from the package; the other rtl files that use it rely on compile order.
`ifndef AIS_CONSTS_SVH
`define AIS_CONSTS_SVH

// ----------------------------------------------------------------
// Device memory map, word addresses on the link
// ----------------------------------------------------------------
`define AIS_A_DATA      8'h01
`define AIS_A_HI_FLG    8'h11
`define AIS_A_LO_FLG    8'h12
`define AIS_A_SC_ACT    8'h28
`define AIS_A_PT_EN     8'h2f
`define AIS_A_SC_EN     8'h31
`define AIS_A_LO_AEN    8'h35
`define AIS_A_HI_AEN    8'h36
`define AIS_A_AL_LIM    8'h37
`define AIS_A_SC_LIM    8'h77
`define AIS_A_WCNT      8'h97
`define AIS_A_CMP       8'h99
`define AIS_A_FMT       8'h9a
`define AIS_NPT         16
`define AIS_NLIM        32
`define AIS_RAW_SPAN    30'sh0fff
`define AIS_WCNT_MAX    16'h270f

// ----------------------------------------------------------------
// Controller registers on APB, byte addresses
// ----------------------------------------------------------------
`define AIS_H_CTRL      12'h000
`define AIS_H_WDAT      12'h004
`define AIS_H_RDAT      12'h008
`define AIS_H_STAT      12'h00c
`define AIS_H_MASK      12'h010
`define AIS_CTRL_WE     8
`define AIS_ST_DONE     0
`define AIS_ST_ALARM    1
`define AIS_ST_BUSY     8

`endif

// file: rtl/ais_pkg.sv
// Types shared by both ends of the analog input scaling link.
// Assumes ais_consts.svh is on the include path.
`include "ais_consts.svh"

package ais_pkg;

    typedef logic [15:0] ais_word_t;

    // ----------------------------------------------------------------
    // Device state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0]                     pt_en_ff;
        logic [15:0]                     sc_en_ff;
        logic [15:0]                     lo_aen_ff;
        logic [15:0]                     hi_aen_ff;
        logic                            fmt_ff;
        logic [`AIS_NLIM-1:0][15:0]      scl_ff;
        logic [`AIS_NLIM-1:0][15:0]      alm_ff;
        logic [`AIS_NPT-1:0][15:0]       res_ff;
        logic [15:0]                     hi_flg_ff;
        logic [15:0]                     lo_flg_ff;
        logic [15:0]                     wcnt_ff;
        logic [15:0]                     cmp_ff;
        logic                            ack_ff;
        logic [15:0]                     rdata_ff;
        logic                            ov_ff;
        logic [3:0]                      opt_ff;
        logic [15:0]                     odat_ff;
        logic                            nv_st_ff;
        logic                            nv_ref_ff;
    } ais_dev_st_t;

    // ----------------------------------------------------------------
    // Controller state
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        AIS_IDLE = 3'b001,
        AIS_REQ  = 3'b010,
        AIS_WAIT = 3'b100
    } ais_hfsm_t;

    typedef struct packed {
        ais_hfsm_t   fsm_ff;
        logic [7:0]  addr_ff;
        logic        we_ff;
        logic [15:0] wdat_ff;
        logic [15:0] rdat_ff;
        logic [1:0]  stat_ff;
        logic [1:0]  mask_ff;
        logic        alm_ff;
        logic [31:0] prdata_ff;
    } ais_host_st_t;

endpackage

// file: rtl/ais_link_if.sv
// Word-access link between the controller and the scaling device.
// Assumes both ends run on the same pclk.
`timescale 1ns/100ps

interface ais_link_if;
    logic        req;
    logic        we;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        ack;
    logic [15:0] rdata;
    logic        alarm;

    modport dev (
        input  req,
        input  we,
        input  addr,
        input  wdata,
        output ack,
        output rdata,
        output alarm
    );

    modport host (
        output req,
        output we,
        output addr,
        output wdata,
        input  ack,
        input  rdata,
        input  alarm
    );
endinterface

// file: rtl/ais_dev.sv
// Scaling device: per-point scaling, alarms on each post-scaling sample, memory map.
// Assumes samples and link requests come from logic on pclk.
//
// What this block does
// - Nonvolatile store refused without confirmation word.
// - Confirmation equal to write count authorises store.
// - Host disables point before reconfiguring it.
// - Enabled functions run before result is stored.
// - Limit alarms judge each un-averaged sample.
// - Scaling maps raw 0..4095 onto low..high.
// - Bounds binary full range or BCD +-7999.
// - Low above high gives inverted output.
// - One scaling enable bit per point.
// - Status word shows scaling active per point.
// - Scale bounds kept contiguous in selected format.
// - Host writes bounds before setting enable.
`timescale 1ns/100ps

module ais_dev (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    ais_link_if.dev          link,
    input  wire logic        smp_valid,
    input  wire logic [3:0]  smp_point,
    input  wire logic [11:0] smp_raw,
    output logic             out_valid,
    output logic [3:0]       out_point,
    output logic [15:0]      out_data,
    output logic             nv_store,
    output logic             nv_refused
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Signed BCD: bit 15 is the sign, four digits below it.
    function automatic logic signed [15:0] bcd2bin(input logic [15:0] v);
        logic [15:0] mag;
        mag = 16'(v[14:12] * 10'd1000) + 16'(v[11:8] * 7'd100)
            + 16'(v[7:4] * 4'd10) + 16'(v[3:0]);
        return v[15] ? -$signed(mag) : $signed(mag);
    endfunction

    function automatic logic [15:0] bin2bcd(input logic signed [15:0] v);
        logic [15:0] mag;
        mag = v[15] ? 16'(-v) : 16'(v);
        return {v[15], 3'(mag / 16'd1000), 4'((mag / 16'd100) % 16'd10),
                4'((mag / 16'd10) % 16'd10), 4'(mag % 16'd10)};
    endfunction

    function automatic logic [15:0] fmt_in(input logic bcd,
                                           input logic [15:0] v);
        return bcd ? 16'(bcd2bin(v)) : v;
    endfunction

    // Truncating signed divide rounds toward zero.
    function automatic logic [15:0] scale(input logic [11:0] raw,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
        logic signed [29:0] span;
        logic signed [29:0] prod;
        logic signed [29:0] quo;
        span = 30'($signed({hi[15], hi}) - $signed({lo[15], lo}));
        prod = $signed({18'h0, raw}) * span;
        quo  = prod / `AIS_RAW_SPAN;
        return 16'(lo + quo[15:0]);
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    ais_pkg::ais_dev_st_t r;
    ais_pkg::ais_dev_st_t nxt_r;

    logic [4:0]  lo_ix;
    logic [4:0]  hi_ix;
    logic [15:0] lo_b;
    logic [15:0] hi_b;
    logic [15:0] alo_b;
    logic [15:0] ahi_b;
    logic [15:0] val;
    logic [15:0] sc_act;
    logic [4:0]  wix;
    logic [7:0]  a;

    assign sc_act     = r.sc_en_ff & r.pt_en_ff;
    assign link.ack   = r.ack_ff;
    assign link.rdata = r.rdata_ff;
    assign link.alarm = |(r.hi_flg_ff | r.lo_flg_ff);
    assign out_valid  = r.ov_ff;
    assign out_point  = r.opt_ff;
    assign out_data   = r.odat_ff;
    assign nv_store   = r.nv_st_ff;
    assign nv_refused = r.nv_ref_ff;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_r           = r;
        nxt_r.ack_ff    = 1'b0;
        nxt_r.ov_ff     = 1'b0;
        nxt_r.nv_st_ff  = 1'b0;
        nxt_r.nv_ref_ff = 1'b0;
        a     = link.addr;
        wix   = 5'(a - `AIS_A_SC_LIM);
        lo_ix = {smp_point, 1'b0};
        hi_ix = {smp_point, 1'b1};
        lo_b  = fmt_in(r.fmt_ff, r.scl_ff[lo_ix]);
        hi_b  = fmt_in(r.fmt_ff, r.scl_ff[hi_ix]);
        alo_b = fmt_in(r.fmt_ff, r.alm_ff[lo_ix]);
        ahi_b = fmt_in(r.fmt_ff, r.alm_ff[hi_ix]);
        if (r.sc_en_ff[smp_point]) begin
            val = scale(smp_raw, lo_b, hi_b);
        end else begin
            val = {4'h0, smp_raw};
        end

        // Link access: clear-on-write of flags comes before sample sets.
        if (link.req) begin
            nxt_r.ack_ff = 1'b1;
            if (link.we) begin
                if (a >= `AIS_A_SC_LIM && a < `AIS_A_WCNT) begin
                    nxt_r.scl_ff[wix] = link.wdata;
                end else if (a >= `AIS_A_AL_LIM && a < `AIS_A_SC_LIM) begin
                    nxt_r.alm_ff[5'(a - `AIS_A_AL_LIM)] = link.wdata;
                end
                case (a)
                    `AIS_A_PT_EN:  nxt_r.pt_en_ff  = link.wdata;
                    `AIS_A_SC_EN:  nxt_r.sc_en_ff  = link.wdata;
                    `AIS_A_LO_AEN: nxt_r.lo_aen_ff = link.wdata;
                    `AIS_A_HI_AEN: nxt_r.hi_aen_ff = link.wdata;
                    `AIS_A_FMT:    nxt_r.fmt_ff    = link.wdata[0];
                    `AIS_A_HI_FLG: nxt_r.hi_flg_ff = r.hi_flg_ff & ~link.wdata;
                    `AIS_A_LO_FLG: nxt_r.lo_flg_ff = r.lo_flg_ff & ~link.wdata;
                    `AIS_A_CMP: begin
                        nxt_r.cmp_ff = link.wdata;
                        if (link.wdata == r.wcnt_ff) begin
                            nxt_r.nv_st_ff = 1'b1;
                            if (r.wcnt_ff != `AIS_WCNT_MAX) begin
                                nxt_r.wcnt_ff = r.wcnt_ff + 16'h0001;
                            end
                        end else begin
                            nxt_r.nv_ref_ff = 1'b1;
                        end
                    end
                    default: ;
                endcase
            end else begin
                nxt_r.rdata_ff = 16'h0000;
                if (a >= `AIS_A_SC_LIM && a < `AIS_A_WCNT) begin
                    nxt_r.rdata_ff = r.scl_ff[wix];
                end else if (a >= `AIS_A_AL_LIM && a < `AIS_A_SC_LIM) begin
                    nxt_r.rdata_ff = r.alm_ff[5'(a - `AIS_A_AL_LIM)];
                end else if (a >= `AIS_A_DATA && a < `AIS_A_HI_FLG) begin
                    nxt_r.rdata_ff = r.res_ff[4'(a - `AIS_A_DATA)];
                end
                case (a)
                    `AIS_A_SC_ACT: nxt_r.rdata_ff = sc_act;
                    `AIS_A_PT_EN:  nxt_r.rdata_ff = r.pt_en_ff;
                    `AIS_A_SC_EN:  nxt_r.rdata_ff = r.sc_en_ff;
                    `AIS_A_LO_AEN: nxt_r.rdata_ff = r.lo_aen_ff;
                    `AIS_A_HI_AEN: nxt_r.rdata_ff = r.hi_aen_ff;
                    `AIS_A_FMT:    nxt_r.rdata_ff = {15'h0, r.fmt_ff};
                    `AIS_A_HI_FLG: nxt_r.rdata_ff = r.hi_flg_ff;
                    `AIS_A_LO_FLG: nxt_r.rdata_ff = r.lo_flg_ff;
                    `AIS_A_WCNT:   nxt_r.rdata_ff = r.wcnt_ff;
                    `AIS_A_CMP:    nxt_r.rdata_ff = r.cmp_ff;
                    default: ;
                endcase
            end
        end

        // Samples of disabled points are dropped, leaving old results.
        if (smp_valid && r.pt_en_ff[smp_point]) begin
            if (r.lo_aen_ff[smp_point] && $signed(val) < $signed(alo_b)) begin
                nxt_r.lo_flg_ff[smp_point] = 1'b1;
            end
            if (r.hi_aen_ff[smp_point] && $signed(val) > $signed(ahi_b)) begin
                nxt_r.hi_flg_ff[smp_point] = 1'b1;
            end
            nxt_r.ov_ff   = 1'b1;
            nxt_r.opt_ff  = smp_point;
            nxt_r.odat_ff = r.fmt_ff ? bin2bcd(val) : val;
            nxt_r.res_ff[smp_point] = nxt_r.odat_ff;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else if (ce) begin
            r <= nxt_r;
        end
    end

endmodule

// file: rtl/ais_host.sv
// Controller end: APB registers turned into word accesses on the link.
// Assumes the device answers every link request with one ack.
`timescale 1ns/100ps

module ais_host (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    ais_link_if.host         link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    output logic             irq
);

    ais_pkg::ais_host_st_t r;
    ais_pkg::ais_host_st_t nxt_r;

    logic acc;
    logic mapped;
    logic [1:0] ev;

    function automatic logic is_mapped(input logic [11:0] a);
        return a == `AIS_H_CTRL || a == `AIS_H_WDAT || a == `AIS_H_RDAT
            || a == `AIS_H_STAT || a == `AIS_H_MASK;
    endfunction

    assign mapped     = is_mapped(paddr);
    assign acc        = psel && penable;
    assign pready     = 1'b1;
    assign pslverr    = acc && !mapped;
    assign prdata     = r.prdata_ff;
    assign irq        = |(r.stat_ff & r.mask_ff);
    assign link.req   = (r.fsm_ff == ais_pkg::AIS_REQ);
    assign link.we    = r.we_ff;
    assign link.addr  = r.addr_ff;
    assign link.wdata = r.wdat_ff;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_r = r;
        ev    = 2'b00;
        nxt_r.alm_ff = link.alarm;
        ev[`AIS_ST_ALARM] = link.alarm && !r.alm_ff;

        // Read data is captured in the setup cycle.
        if (psel && !penable) begin
            nxt_r.prdata_ff = 32'h0000_0000;
            case (paddr)
                `AIS_H_CTRL: nxt_r.prdata_ff = {23'h0, r.we_ff, r.addr_ff};
                `AIS_H_WDAT: nxt_r.prdata_ff = {16'h0, r.wdat_ff};
                `AIS_H_RDAT: nxt_r.prdata_ff = {16'h0, r.rdat_ff};
                `AIS_H_STAT: begin
                    nxt_r.prdata_ff = {30'h0, r.stat_ff};
                    nxt_r.prdata_ff[`AIS_ST_BUSY] =
                        (r.fsm_ff != ais_pkg::AIS_IDLE);
                end
                `AIS_H_MASK: nxt_r.prdata_ff = {30'h0, r.mask_ff};
                default: ;
            endcase
        end

        case (r.fsm_ff)
            ais_pkg::AIS_IDLE: begin
                if (acc && pwrite && paddr == `AIS_H_CTRL) begin
                    nxt_r.addr_ff = pwdata[7:0];
                    nxt_r.we_ff   = pwdata[`AIS_CTRL_WE];
                    nxt_r.fsm_ff  = ais_pkg::AIS_REQ;
                end
            end
            ais_pkg::AIS_REQ: nxt_r.fsm_ff = ais_pkg::AIS_WAIT;
            ais_pkg::AIS_WAIT: begin
                if (link.ack) begin
                    nxt_r.rdat_ff = link.rdata;
                    ev[`AIS_ST_DONE] = 1'b1;
                    nxt_r.fsm_ff  = ais_pkg::AIS_IDLE;
                end
            end
            default: nxt_r.fsm_ff = ais_pkg::AIS_IDLE;
        endcase

        if (acc && pwrite && paddr == `AIS_H_WDAT
            && r.fsm_ff == ais_pkg::AIS_IDLE) begin
            nxt_r.wdat_ff = pwdata[15:0];
        end
        if (acc && pwrite && paddr == `AIS_H_MASK) begin
            nxt_r.mask_ff = pwdata[1:0];
        end
        // Read clears only the bits it reported; newer events survive.
        if (acc && !pwrite && paddr == `AIS_H_STAT) begin
            nxt_r.stat_ff = r.stat_ff & ~r.prdata_ff[1:0];
        end
        nxt_r.stat_ff = nxt_r.stat_ff | ev;
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r        <= '0;
            r.fsm_ff <= ais_pkg::AIS_IDLE;
        end else if (ce) begin
            r <= nxt_r;
        end
    end

endmodule

// file: bench/ais_link_chk.sv
// Checker for the word link between the controller and the scaling device.
// Assumes one pclk domain and presetn asynchronous, active low.
`timescale 1ns/100ps

module ais_link_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        req,
    input wire logic        we,
    input wire logic [7:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        ack,
    input wire logic [15:0] rdata,
    input wire logic        alarm
);
    // ------------------------------------------------------------
    // Shadow of the words written over the link
    // ------------------------------------------------------------
    logic [15:0] pt_h_ff;
    logic [15:0] sc_h_ff;
    logic [15:0] cnt_h_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pt_h_ff  <= 16'h0000;
            sc_h_ff  <= 16'h0000;
            cnt_h_ff <= 16'h0000;
        end else if (req && we) begin
            if (addr == 8'h2f) pt_h_ff <= wdata;
            if (addr == 8'h31) sc_h_ff <= wdata;
            if (addr == 8'h99 && wdata == cnt_h_ff && cnt_h_ff != 16'h270f)
                cnt_h_ff <= cnt_h_ff + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_ack_follows: assert property (req |=> ack)
        else $error("link request not answered one cycle later");
    a_ack_cause: assert property (ack |-> $past(req))
        else $error("link answer without a request");
    a_ack_pulse: assert property (ack |=> !ack)
        else $error("link answer longer than one cycle");
    a_req_gap: assert property (req |=> !req ##1 !req)
        else $error("link requests closer than three cycles");
    a_rdata_hold: assert property (!ack |-> $stable(rdata))
        else $error("read data changed without an answer");
    a_active_word: assert property (req && !we && addr == 8'h28
        |=> rdata == (pt_h_ff & sc_h_ff))
        else $error("scaling active word wrong");
    a_count_word: assert property (req && !we && addr == 8'h97
        |=> rdata == cnt_h_ff)
        else $error("write count word wrong");
    a_point_back: assert property (req && !we && addr == 8'h2f
        |=> rdata == pt_h_ff)
        else $error("point enable word readback wrong");
    a_scale_back: assert property (req && !we && addr == 8'h31
        |=> rdata == sc_h_ff)
        else $error("scaling enable word readback wrong");
    a_alarm_clear: assert property ($fell(alarm) |-> ack
        && $past(we && (addr == 8'h11 || addr == 8'h12)))
        else $error("alarm dropped without a flag clear");

    c_store: cover property (req && we && addr == 8'h99);
    c_alarm: cover property ($rose(alarm));
    c_active: cover property (req && !we && addr == 8'h28);
endmodule

// file: bench/test_analog_input_scaling.sv
// Self-checking bench: APB controller and scaling device joined by link.
// Assumes the rtl files and ais_consts.svh are compiled before it.
`timescale 1ns/100ps

module test_analog_input_scaling;
    logic        pclk, presetn, ce, psel, penable, pwrite, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic        pready, pslverr, irq, smp_valid, out_valid;
    logic [3:0]  smp_point, out_point;
    logic [11:0] smp_raw;
    logic [15:0] out_data;
    logic        nv_store, nv_refused;
    int          bad_count, comparisons, n_st, n_ref;
    logic [3:0]  tp   [5] = '{4'h1, 4'h6, 4'hc, 4'h3, 4'hf};
    logic [15:0] tlo  [5] = '{16'h0000, 16'h0019, 16'h004b, 16'h0064, 16'h8000};
    logic [15:0] thi  [5] = '{16'h1388, 16'h0064, 16'h04b0, 16'hff38, 16'h7fff};
    logic [11:0] traw [5] = '{12'hfff, 12'h800, 12'h400, 12'h3e8, 12'h001};

    ais_link_if link ();
    ais_host u_ais_host (.pclk(pclk), .presetn(presetn), .ce(ce),
        .link(link), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .irq(irq));
    ais_dev u_ais_dev (.pclk(pclk), .presetn(presetn), .ce(ce),
        .link(link), .smp_valid(smp_valid), .smp_point(smp_point),
        .smp_raw(smp_raw), .out_valid(out_valid), .out_point(out_point),
        .out_data(out_data), .nv_store(nv_store), .nv_refused(nv_refused));
    ais_link_chk u_ais_link_chk (.pclk(pclk), .presetn(presetn),
        .req(link.req), .we(link.we), .addr(link.addr),
        .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata),
        .alarm(link.alarm));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        if (nv_store === 1'b1) n_st++;
        if (nv_refused === 1'b1) n_ref++;
    end

    // ------------------------------------------------------------
    // Bus and sample tasks
    // ------------------------------------------------------------
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (pready !== 1'b1) begin
            bad_count++;
            stop_test();
        end
        rv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_done;
        int n;
        n = 0;
        do begin
            apb(1'b0, 12'h00c, 32'h00000000);
            n++;
        end while (rv[0] !== 1'b1 && n < 20);
        if (rv[0] !== 1'b1) begin
            bad_count++;
            stop_test();
        end
    endtask

    task automatic dev_wr(input logic [7:0] a, input logic [15:0] d);
        apb(1'b1, 12'h004, {16'h0000, d});
        apb(1'b1, 12'h000, {23'h000000, 1'b1, a});
        wait_done();
    endtask

    task automatic rchk(input string nm, input logic [7:0] a,
                        input logic [15:0] e);
        apb(1'b1, 12'h000, {24'h000000, a});
        wait_done();
        apb(1'b0, 12'h008, 32'h00000000);
        check(nm, {16'h0000, rv[15:0]}, {16'h0000, e});
    endtask

    task automatic smp(input logic [3:0] p, input logic [11:0] r,
                       input logic [15:0] e, input logic en);
        @(posedge pclk);
        smp_valid <= 1'b1;
        smp_point <= p;
        smp_raw <= r;
        @(posedge pclk);
        smp_valid <= 1'b0;
        #1;
        check("out_valid", {31'h0, out_valid}, {31'h0, en});
        if (en) begin
            check("out_point", {28'h0, out_point}, {28'h0, p});
            check("out_data", {16'h0, out_data}, {16'h0, e});
        end
    endtask

    function automatic logic [15:0] scl(input logic [15:0] lo, hi,
                                        input logic [11:0] r);
        int l;
        int h;
        l = $signed(lo);
        h = $signed(hi);
        return 16'(l + (int'(r) * (h - l)) / 4095);
    endfunction

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        ce = 1'b1;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        smp_valid = 1'b0;
        smp_point = 4'h0;
        smp_raw = 12'h000;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rchk("active_rst", 8'h28, 16'h0000);
        rchk("count_rst", 8'h97, 16'h0000);
        apb(1'b0, 12'h020, 32'h00000000);
        check("pslverr", {31'h0, err}, 32'h00000001);
        rchk("unmapped", 8'h20, 16'h0000);
        for (int i = 0; i < 5; i++) begin
            dev_wr(8'h77 + {3'h0, tp[i], 1'b0}, tlo[i]);
            dev_wr(8'h78 + {3'h0, tp[i], 1'b0}, thi[i]);
        end
        dev_wr(8'h31, 16'h904a);
        rchk("active_off", 8'h28, 16'h0000);
        dev_wr(8'h2f, 16'h904b);
        dev_wr(8'h28, 16'hffff);
        rchk("active_on", 8'h28, 16'h904a);
        rchk("scale_en", 8'h31, 16'h904a);
        for (int i = 0; i < 5; i++) begin
            smp(tp[i], traw[i], scl(tlo[i], thi[i], traw[i]), 1'b1);
            smp(tp[i], 12'h000, tlo[i], 1'b1);
        end
        smp(4'h0, 12'habc, 16'h0abc, 1'b1);
        smp(4'h2, 12'h123, 16'h0000, 1'b0);
        // With the clock enable low a sample leaves no trace.
        @(posedge pclk);
        ce <= 1'b0;
        smp(4'h0, 12'h123, 16'h0000, 1'b0);
        @(posedge pclk);
        ce <= 1'b1;
        rchk("result_pt0", 8'h01, 16'h0abc);
        // Point 3 goes offline, takes new bounds, then comes back.
        dev_wr(8'h2f, 16'h9043);
        smp(4'h3, 12'hfff, 16'h0000, 1'b0);
        dev_wr(8'h7d, 16'hff38);
        dev_wr(8'h7e, 16'h0064);
        dev_wr(8'h2f, 16'h904b);
        smp(4'h3, 12'hfff, 16'h0064, 1'b1);
        smp(4'h3, 12'h000, 16'hff38, 1'b1);
        dev_wr(8'h9a, 16'h0001);
        dev_wr(8'h95, 16'hf999);
        dev_wr(8'h96, 16'h7999);
        smp(4'hf, 12'hfff, 16'h7999, 1'b1);
        smp(4'hf, 12'h000, 16'hf999, 1'b1);
        dev_wr(8'h9a, 16'h0000);
        // High alarm on point 1: raised, seen, cleared, then masked.
        apb(1'b1, 12'h010, 32'h00000002);
        dev_wr(8'h3a, 16'h03e8);
        dev_wr(8'h36, 16'h0002);
        smp(4'h1, 12'hfff, 16'h1388, 1'b1);
        repeat (3) @(posedge pclk);
        #1;
        check("irq", {31'h0, irq}, 32'h00000001);
        apb(1'b0, 12'h00c, 32'h00000000);
        check("stat_alarm", {31'h0, rv[1]}, 32'h00000001);
        #1;
        check("irq_clear", {31'h0, irq}, 32'h00000000);
        rchk("hi_flags", 8'h11, 16'h0002);
        dev_wr(8'h11, 16'h0002);
        rchk("hi_clear", 8'h11, 16'h0000);
        apb(1'b1, 12'h010, 32'h00000000);
        smp(4'h1, 12'hfff, 16'h1388, 1'b1);
        repeat (3) @(posedge pclk);
        #1;
        check("irq_mask", {31'h0, irq}, 32'h00000000);
        apb(1'b0, 12'h00c, 32'h00000000);
        check("stat_mask", {31'h0, rv[1]}, 32'h00000001);
        // Store refused, then authorised, then refused with a stale word.
        dev_wr(8'h99, 16'h0005);
        dev_wr(8'h99, 16'h0000);
        rchk("count", 8'h97, 16'h0001);
        dev_wr(8'h99, 16'h0000);
        check("stores", n_st, 32'h00000001);
        check("refusals", n_ref, 32'h00000002);
        stop_test();
    end
endmodule
